// ---- hw/gpib_pkg.sv ----
/*
  constants, command codes and carrier types for the bus port.
  assumes one 100 MHz clock and bus lines given in asserted-true form.
*/
package gpib_pkg;
  localparam int          clk_mhz       = 100;
  // least settle time before data valid, ns
  localparam int          settle_ns     = 2000;
  localparam int          settle_calc   = (settle_ns * clk_mhz + 999) / 1000;
  localparam logic [7:0]  settle_cycles = settle_calc[7:0];

  // command bytes, low seven bits
  localparam logic [6:0]  cmd_gtl  = 7'h01;
  localparam logic [6:0]  cmd_sdc  = 7'h04;
  localparam logic [6:0]  cmd_ppc  = 7'h05;
  localparam logic [6:0]  cmd_get  = 7'h08;
  localparam logic [6:0]  cmd_llo  = 7'h11;
  localparam logic [6:0]  cmd_dcl  = 7'h14;
  localparam logic [6:0]  cmd_ppu  = 7'h15;
  localparam logic [6:0]  cmd_spe  = 7'h18;
  localparam logic [6:0]  cmd_spd  = 7'h19;
  localparam logic [6:0]  cmd_unl  = 7'h3F;
  localparam logic [6:0]  cmd_unt  = 7'h5F;
  localparam logic [1:0]  grp_listen = 2'h1;
  localparam logic [1:0]  grp_talk   = 2'h2;

  localparam int          rqs_bit       = 6;
  localparam int          local_key_idx = 0;
  localparam int          key_count     = 8;

  typedef enum logic [1:0] {
    trig_ext = 2'h0,
    trig_bus = 2'h1,
    trig_imm = 2'h2
  } trig_src_t;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } byte_t;

  typedef struct packed {
    logic [7:0] dio;
    logic       dav;
    logic       nrfd;
    logic       ndac;
    logic       eoi;
    logic       atn;
    logic       ifc;
    logic       ren;
  } bus_in_t;

  typedef struct packed {
    logic [7:0] dio;
    logic       dio_oe;
    logic       dav;
    logic       dav_oe;
    logic       nrfd;
    logic       nrfd_oe;
    logic       ndac;
    logic       ndac_oe;
    logic       eoi;
    logic       eoi_oe;
    logic       srq;
    logic       srq_oe;
  } bus_out_t;
endpackage : gpib_pkg

// ---- hw/gpib_acceptor.sv ----
/*
  acceptor three-wire handshake, one byte per cycle of dav.
  assumes bus lines are synchronous and given asserted-true.
*/
`timescale 1ns/1ps
module gpib_acceptor (
  // clock and reset
  input  wire logic           mclk,
  input  wire logic           rst_n,
  // control
  input  wire logic           active,
  input  wire logic           ready,
  // bus
  input  wire logic           dav,
  input  wire logic [7:0]     dio,
  input  wire logic           eoi,
  output logic                nrfd_assert,
  output logic                ndac_assert,
  // captured byte
  output logic                take,
  output gpib_pkg::byte_t     rx
);
  typedef enum logic [1:0] {
    ah_not_ready = 2'h0,
    ah_ready     = 2'h1,
    ah_accept    = 2'h3,
    ah_wait      = 2'h2
  } ah_state_t;

  ah_state_t       state, next_state;
  logic            next_take;
  gpib_pkg::byte_t next_rx;

  always_comb
  begin
    next_state = state;
    next_take  = 1'b0;
    next_rx    = rx;
    unique case (state)
      ah_not_ready:
        if (ready) next_state = ah_ready;
      ah_ready:
        if (dav)
        begin
          next_state = ah_accept;
          next_rx    = '{data: dio, last: eoi};
          next_take  = 1'b1;
        end
        else if (!ready) next_state = ah_not_ready;
      ah_accept:
        next_state = ah_wait;
      ah_wait:
        if (!dav) next_state = ah_not_ready;
    endcase
    if (!active) next_state = ah_not_ready;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state <= ah_not_ready;
      take  <= 1'b0;
      rx    <= '0;
    end
    else
    begin
      state <= next_state;
      take  <= next_take;
      rx    <= next_rx;
    end
  end

  assign nrfd_assert = active && (state != ah_ready);
  assign ndac_assert = active && (state != ah_accept) && (state != ah_wait);
endmodule : gpib_acceptor

// ---- hw/gpib_source.sv ----
/*
  source three-wire handshake with settle delay before data valid.
  assumes listeners obey the acceptor handshake.
*/
`timescale 1ns/1ps
module gpib_source (
  // clock and reset
  input  wire logic           mclk,
  input  wire logic           rst_n,
  // control
  input  wire logic           active,
  input  wire logic           start,
  input  wire gpib_pkg::byte_t tx,
  output logic                busy,
  output logic                done,
  // bus
  input  wire logic           nrfd,
  input  wire logic           ndac,
  output logic                dav_assert,
  output gpib_pkg::byte_t     out
);
  typedef enum logic [1:0] {
    sh_idle    = 2'h0,
    sh_settle  = 2'h1,
    sh_valid   = 2'h3,
    sh_release = 2'h2
  } sh_state_t;

  sh_state_t       state, next_state;
  logic [7:0]      cnt, next_cnt;
  logic            next_done;
  gpib_pkg::byte_t next_out;

  always_comb
  begin
    next_state = state;
    next_cnt   = cnt;
    next_done  = 1'b0;
    next_out   = out;
    unique case (state)
      sh_idle:
        if (start)
        begin
          next_state = sh_settle;
          next_out   = tx;
          next_cnt   = 8'h00;
        end
      sh_settle:
      begin
        if (cnt < gpib_pkg::settle_cycles) next_cnt = cnt + 8'h01;
        if (cnt >= gpib_pkg::settle_cycles - 8'h01 && !nrfd && ndac)
          next_state = sh_valid;
      end
      sh_valid:
        if (!ndac)
        begin
          next_state = sh_release;
          next_done  = 1'b1;
        end
      sh_release:
        if (ndac) next_state = sh_idle;
    endcase
    if (!active) next_state = sh_idle;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state <= sh_idle;
      cnt   <= 8'h00;
      done  <= 1'b0;
      out   <= '0;
    end
    else
    begin
      state <= next_state;
      cnt   <= next_cnt;
      done  <= next_done;
      out   <= next_out;
    end
  end

  assign busy       = (state != sh_idle);
  assign dav_assert = (state == sh_valid);
endmodule : gpib_source

// ---- hw/gpib_talker_listener_port.sv ----
/*
  instrument side of the bus: addressing, talk and listen data paths,
  serial poll, service request, remote/local, clear and trigger.
  assumes bus lines synchronous to mclk, asserted-true, resolved outside.
*/
`timescale 1ns/1ps
// Summary of operation
// - full source and acceptor handshakes carry multi-byte messages over dav, nrfd, ndac.
// - basic talker with serial poll; own listen address ends talker state.
// - basic listener; own talk address ends listener state.
// - srq asserted while a service request stands and has not yet been serially polled.
// - local mode passes front panel; bus command switches to remote.
// - in remote all front panel keys are ignored except the local key.
// - keypad lockout also blocks local key; only remote select command, ren release or reset restores local.
// - universal and selected device clear both perform a device clear.
// - addressed group trigger or common trigger command fires a trigger.
// - go-to-local is ignored; remote select command with zero returns local.
// - trigger source is external input, bus commands, or immediate.
// - every command and data byte passes through the handshake as talker or listener.
// - recognise attention, clear, addresses, unlisten, untalk, poll; send status with rqs.
module gpib_talker_listener_port (
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                rst_n,
  // bus pins
  input  wire gpib_pkg::bus_in_t   bus_in,
  output gpib_pkg::bus_out_t       bus_out,
  input  wire logic [4:0]          my_addr,
  // talk data
  input  wire logic                tx_valid,
  input  wire gpib_pkg::byte_t     tx,
  output logic                     tx_ready,
  // listen data
  output logic                     rx_valid,
  output gpib_pkg::byte_t          rx,
  input  wire logic                rx_ready,
  input  wire logic                eos_enable,
  input  wire logic [7:0]          eos_char,
  // service request
  input  wire logic [7:0]          status_byte,
  input  wire logic                service_req,
  // front panel and remote control
  input  wire logic [7:0]          keys_in,
  output logic [7:0]               keys_out,
  input  wire logic                lockout_cmd,
  input  wire logic                remote_mode_select_command,
  input  wire logic                remote_mode_arg,
  output logic                     remote,
  output logic                     lockout,
  // trigger and clear
  input  wire gpib_pkg::trig_src_t trig_src,
  input  wire logic                ext_trig,
  input  wire logic                trg_cmd,
  input  wire logic                trig_arm,
  output logic                     trigger,
  output logic                     dev_clear,
  // state
  output logic                     talker,
  output logic                     listener,
  output logic                     serial_poll
);
  logic            ah_active, ah_ready, ah_nrfd, ah_ndac, ah_take;
  gpib_pkg::byte_t ah_byte;
  logic            sh_active, sh_start, sh_busy, sh_done, sh_dav;
  gpib_pkg::byte_t sh_byte, sh_out;

  logic            cmd_take, data_take;
  logic [6:0]      cmd;
  logic            is_mla, is_mta, is_ota;
  logic            poll_send;
  logic            srq_sent, next_srq_sent;
  logic            ext_prev;
  logic            next_talker, next_listener, next_serial_poll;
  logic            next_remote, next_lockout;
  logic            next_trigger, next_dev_clear;
  logic            next_rx_valid;
  gpib_pkg::byte_t next_rx;
  logic [7:0]      next_keys_out;

  // handshake engines
  gpib_acceptor u_acceptor (
    .mclk        (mclk),
    .rst_n       (rst_n),
    .active      (ah_active),
    .ready       (ah_ready),
    .dav         (bus_in.dav),
    .dio         (bus_in.dio),
    .eoi         (bus_in.eoi),
    .nrfd_assert (ah_nrfd),
    .ndac_assert (ah_ndac),
    .take        (ah_take),
    .rx          (ah_byte)
  );

  gpib_source u_source (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .active     (sh_active),
    .start      (sh_start),
    .tx         (sh_byte),
    .busy       (sh_busy),
    .done       (sh_done),
    .nrfd       (bus_in.nrfd),
    .ndac       (bus_in.ndac),
    .dav_assert (sh_dav),
    .out        (sh_out)
  );

  // acceptor joins every command byte, data bytes only when listening
  assign ah_active = !bus_in.ifc && (bus_in.atn || listener);
  assign ah_ready  = bus_in.atn || !rx_valid;
  assign cmd_take  = ah_take && bus_in.atn;
  assign data_take = ah_take && !bus_in.atn && listener;
  assign cmd       = ah_byte.data[6:0];

  // address decode
  assign is_mla = (cmd[6:5] == gpib_pkg::grp_listen) && (cmd[4:0] == my_addr)
                  && (cmd != gpib_pkg::cmd_unl);
  assign is_mta = (cmd[6:5] == gpib_pkg::grp_talk) && (cmd[4:0] == my_addr)
                  && (cmd != gpib_pkg::cmd_unt);
  assign is_ota = (cmd[6:5] == gpib_pkg::grp_talk) && (cmd[4:0] != my_addr)
                  && (cmd != gpib_pkg::cmd_unt);

  // source talks only while addressed and attention is released
  assign sh_active = talker && !bus_in.atn && !bus_in.ifc;
  assign poll_send = sh_active && serial_poll && !sh_busy;
  assign tx_ready  = sh_active && !serial_poll && !sh_busy;
  assign sh_start  = poll_send || (tx_ready && tx_valid);

  always_comb
  begin
    sh_byte = tx;
    if (serial_poll)
    begin
      sh_byte.data          = status_byte;
      sh_byte.data[gpib_pkg::rqs_bit] = service_req && !srq_sent;
      sh_byte.last          = 1'b0;
    end
  end

  // addressing and serial poll state
  always_comb
  begin
    next_talker      = talker;
    next_listener    = listener;
    next_serial_poll = serial_poll;
    if (cmd_take)
    begin
      if (is_mla)
      begin
        next_listener = 1'b1;
        next_talker   = 1'b0;
      end
      if (is_mta)
      begin
        next_talker   = 1'b1;
        next_listener = 1'b0;
      end
      if (is_ota || cmd == gpib_pkg::cmd_unt) next_talker = 1'b0;
      if (cmd == gpib_pkg::cmd_unl) next_listener = 1'b0;
      if (cmd == gpib_pkg::cmd_spe) next_serial_poll = 1'b1;
      if (cmd == gpib_pkg::cmd_spd) next_serial_poll = 1'b0;
    end
    if (bus_in.ifc)
    begin
      next_talker      = 1'b0;
      next_listener    = 1'b0;
      next_serial_poll = 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      talker      <= 1'b0;
      listener    <= 1'b0;
      serial_poll <= 1'b0;
    end
    else
    begin
      talker      <= next_talker;
      listener    <= next_listener;
      serial_poll <= next_serial_poll;
    end
  end

  // service request: released once polled, rearmed when request drops
  always_comb
  begin
    next_srq_sent = srq_sent;
    if (!service_req) next_srq_sent = 1'b0;
    else if (sh_done && serial_poll) next_srq_sent = 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n) srq_sent <= 1'b0;
    else srq_sent <= next_srq_sent;
  end

  // listen data holding register
  always_comb
  begin
    next_rx_valid = rx_valid;
    next_rx       = rx;
    if (rx_valid && rx_ready) next_rx_valid = 1'b0;
    if (data_take)
    begin
      next_rx_valid = 1'b1;
      next_rx.data  = ah_byte.data;
      next_rx.last  = ah_byte.last || (eos_enable && ah_byte.data == eos_char);
    end
    if (dev_clear) next_rx_valid = 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      rx_valid <= 1'b0;
      rx       <= '0;
    end
    else
    begin
      rx_valid <= next_rx_valid;
      rx       <= next_rx;
    end
  end

  // remote, local and keypad lockout
  always_comb
  begin
    next_remote   = remote;
    next_lockout  = lockout;
    next_keys_out = remote ? 8'h00 : keys_in;
    if (cmd_take && is_mla && bus_in.ren) next_remote = 1'b1;
    if (cmd_take && cmd == gpib_pkg::cmd_llo) next_lockout = 1'b1;
    if (lockout_cmd) next_lockout = 1'b1;
    if (remote && !lockout && keys_in[gpib_pkg::local_key_idx])
      next_remote = 1'b0;
    if (remote_mode_select_command)
      next_remote = remote_mode_arg;
    if (!bus_in.ren)
    begin
      next_remote  = 1'b0;
      next_lockout = 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      remote   <= 1'b0;
      lockout  <= 1'b0;
      keys_out <= 8'h00;
    end
    else
    begin
      remote   <= next_remote;
      lockout  <= next_lockout;
      keys_out <= next_keys_out;
    end
  end

  // clear and trigger; go-to-local and poll setup bytes fall through
  always_comb
  begin
    next_dev_clear = cmd_take && ((cmd == gpib_pkg::cmd_dcl) ||
                     (listener && cmd == gpib_pkg::cmd_sdc));
    next_trigger   = 1'b0;
    unique case (trig_src)
      gpib_pkg::trig_ext: next_trigger = ext_trig && !ext_prev;
      gpib_pkg::trig_bus: next_trigger = trg_cmd ||
                          (cmd_take && listener && cmd == gpib_pkg::cmd_get);
      gpib_pkg::trig_imm: next_trigger = trig_arm;
      default:            next_trigger = 1'b0;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      dev_clear <= 1'b0;
      trigger   <= 1'b0;
      ext_prev  <= 1'b0;
    end
    else
    begin
      dev_clear <= next_dev_clear;
      trigger   <= next_trigger;
      ext_prev  <= ext_trig;
    end
  end

  // pin drive; open-collector lines use enable as the pull
  always_comb
  begin
    bus_out         = '0;
    bus_out.dio     = sh_out.data;
    bus_out.dio_oe  = sh_active && sh_busy;
    bus_out.dav     = 1'b1;
    bus_out.dav_oe  = sh_active && sh_dav;
    bus_out.eoi     = 1'b1;
    bus_out.eoi_oe  = sh_active && sh_busy && sh_out.last;
    bus_out.nrfd    = 1'b1;
    bus_out.nrfd_oe = ah_nrfd;
    bus_out.ndac    = 1'b1;
    bus_out.ndac_oe = ah_ndac;
    bus_out.srq     = 1'b1;
    bus_out.srq_oe  = service_req && !srq_sent;
  end
  // no atn, ifc or parallel poll drive exists on this port
endmodule : gpib_talker_listener_port

// ---- verif/gpib_port_assertions.sv ----
/*
  concurrent checks on the outputs of the bus port.
  assumes one clock, mclk, and a synchronous active-low rst_n.
*/
`timescale 1ns/1ps
module gpib_port_checker (
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                rst_n,
  // bus
  input  wire gpib_pkg::bus_in_t   bus_in,
  input  wire gpib_pkg::bus_out_t  bus_out,
  // user side
  input  wire logic [7:0]          keys_in,
  input  wire logic [7:0]          keys_out,
  input  wire logic                remote_mode_select_command,
  input  wire logic                service_req,
  input  wire gpib_pkg::trig_src_t trig_src,
  input  wire logic                ext_trig,
  // state
  input  wire logic                remote,
  input  wire logic                lockout,
  input  wire logic                trigger,
  input  wire logic                dev_clear,
  input  wire logic                talker,
  input  wire logic                listener,
  input  wire logic                serial_poll
);
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  a_talk_listen_excl: assert property (!(talker && listener))
    else $error("talker and listener together");
  a_dav_when_ready: assert property ($rose(bus_out.dav_oe) |->
    !$past(bus_in.nrfd) && $past(bus_in.ndac))
    else $error("data valid without ready");
  a_ifc_unaddr: assert property (bus_in.ifc |=> !talker && !listener && !serial_poll)
    else $error("interface clear kept addressing");
  a_dio_quiet_atn: assert property (bus_in.atn || bus_in.ifc |-> !bus_out.dio_oe)
    else $error("data driven under attention");
  a_srq_on_req: assert property ($rose(service_req) |-> bus_out.srq_oe)
    else $error("service request not raised");
  a_srq_cause: assert property (bus_out.srq_oe |-> service_req)
    else $error("service request without cause");
  a_keys_blocked: assert property (remote && $past(remote) |-> keys_out == 8'h00)
    else $error("keys passed in remote");
  a_keys_pass: assert property (!remote && !$past(remote) && $past(rst_n) |->
    keys_out == $past(keys_in))
    else $error("keys not passed in local");
  a_lock_holds: assert property (remote && lockout && bus_in.ren
    && !remote_mode_select_command |=> remote)
    else $error("left remote under lockout");
  a_ren_local: assert property (!bus_in.ren |=> !remote && !lockout)
    else $error("remote kept without enable");
  a_trig_pulse: assert property (trigger |=> !trigger)
    else $error("trigger longer than one cycle");
  a_clear_pulse: assert property (dev_clear |=> !dev_clear)
    else $error("device clear longer than one cycle");
  a_ext_edge: assert property (trig_src == gpib_pkg::trig_ext && $rose(ext_trig)
    |-> ##[1:2] trigger)
    else $error("external edge gave no trigger");
endmodule : gpib_port_checker

bind gpib_talker_listener_port gpib_port_checker chk_u (
  .mclk, .rst_n, .bus_in, .bus_out, .keys_in, .keys_out, .remote_mode_select_command,
  .service_req, .trig_src, .ext_trig, .remote, .lockout, .trigger, .dev_clear,
  .talker, .listener, .serial_poll
);

// ---- verif/gpib_host_model.sv ----
/*
  controller-in-charge model: sends command and data bytes, reads bytes.
  assumes device lines asserted-true, pulled only while their enable is high.
*/
`timescale 1ns/1ps
module gpib_host_model (
  // clock
  input  wire logic               mclk,
  // bus
  input  wire gpib_pkg::bus_out_t bus_out,
  output gpib_pkg::bus_in_t       bus_in
);
  logic [7:0] c_dio;
  logic       c_dav, c_nrfd, c_ndac, c_eoi, atn, ifc, ren;
  int         n;

  // wired lines, released level is the pull-up (0 here)
  always_comb
  begin
    bus_in.dio  = c_dio | (bus_out.dio_oe ? bus_out.dio : 8'h00);
    bus_in.dav  = c_dav | bus_out.dav_oe;
    bus_in.nrfd = c_nrfd | bus_out.nrfd_oe;
    bus_in.ndac = c_ndac | bus_out.ndac_oe;
    bus_in.eoi  = c_eoi | bus_out.eoi_oe;
    bus_in.atn  = atn;
    bus_in.ifc  = ifc;
    bus_in.ren  = ren;
  end

  initial
  begin
    {c_dio, c_dav, c_nrfd, c_ndac, c_eoi, atn, ifc, ren} = '0;
  end

  // one byte as source, command when at is high
  task put(input logic [7:0] b, input logic at, input logic e);
  begin
    @(negedge mclk);
    atn    = at;
    c_nrfd = 1'b0;
    c_ndac = 1'b0;
    c_dio  = b;
    c_eoi  = e;
    for (n = 0; n < 500 && (bus_in.nrfd || !bus_in.ndac); n++) @(negedge mclk);
    c_dav = 1'b1;
    for (n = 0; n < 500 && bus_in.ndac; n++) @(negedge mclk);
    c_dav = 1'b0;
    c_dio = 8'h00;
    c_eoi = 1'b0;
    for (n = 0; n < 500 && !bus_in.ndac; n++) @(negedge mclk);
  end
  endtask : put

  // one byte as acceptor, then hold off further bytes
  task get(output logic [7:0] b, output logic e);
  begin
    @(negedge mclk);
    atn    = 1'b0;
    c_nrfd = 1'b0;
    c_ndac = 1'b1;
    for (n = 0; n < 900 && !bus_in.dav; n++) @(negedge mclk);
    b      = bus_in.dio;
    e      = bus_in.eoi;
    c_ndac = 1'b0;
    for (n = 0; n < 500 && bus_in.dav; n++) @(negedge mclk);
    c_nrfd = 1'b1;
    c_ndac = 1'b1;
  end
  endtask : get
endmodule : gpib_host_model

// ---- verif/test_gpib_talker_listener_port.sv ----
/*
  self-checking bench for the bus port, host model on the bus side.
  assumes 100 MHz mclk and inputs driven at the falling edge.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin bad_count++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module test_gpib_talker_listener_port;
  localparam logic [7:0] mla = 8'h25;
  localparam logic [7:0] mta = 8'h45;
  logic mclk, rst_n, tx_valid, tx_ready, rx_valid, rx_ready, eos_enable, service_req;
  logic lockout_cmd, remote_mode_select_command, remote_mode_arg, remote, lockout;
  logic ext_trig, trg_cmd, trig_arm, trigger, dev_clear, talker, listener, serial_poll, ge;
  logic [4:0] my_addr;
  logic [7:0] eos_char, status_byte, keys_in, keys_out, gb;
  gpib_pkg::bus_in_t   bus_in;
  gpib_pkg::bus_out_t  bus_out;
  gpib_pkg::byte_t     tx, rx;
  gpib_pkg::byte_t     rxq[$];
  gpib_pkg::trig_src_t trig_src;
  int bad_count, n_tests, trig_n, clr_n, c0, t0, i;

  gpib_talker_listener_port dut_u (.mclk, .rst_n, .bus_in, .bus_out, .my_addr, .tx_valid,
    .tx, .tx_ready, .rx_valid, .rx, .rx_ready, .eos_enable, .eos_char, .status_byte,
    .service_req, .keys_in, .keys_out, .lockout_cmd, .remote_mode_select_command,
    .remote_mode_arg, .remote, .lockout, .trig_src, .ext_trig, .trg_cmd, .trig_arm,
    .trigger, .dev_clear, .talker, .listener, .serial_poll);
  gpib_host_model host_u (.mclk, .bus_out, .bus_in);

  always #5 mclk = ~mclk;
  always @(posedge mclk)
  begin
    if (rx_valid && rx_ready) rxq.push_back(rx);
    if (trigger) trig_n++;
    if (dev_clear) clr_n++;
  end

  task tick(input int k);
    repeat (k) @(negedge mclk);
  endtask : tick
  task cmd(input logic [7:0] b);
  begin
    host_u.put(b, 1'b1, 1'b0);
    tick(3);
  end
  endtask : cmd

  task t_listen;
  begin
    host_u.ren = 1'b1;
    cmd(mla);
    `CHK("listener", 1'b1, listener)
    `CHK("remote", 1'b1, remote)
    host_u.put(8'h41, 1'b0, 1'b0);
    host_u.put(8'h0A, 1'b0, 1'b0);
    host_u.put(8'h42, 1'b0, 1'b1);
    tick(4);
    `CHK("rx count", 3, rxq.size())
    `CHK("rx 0", {8'h41, 1'b0}, rxq[0])
    `CHK("rx eos", {8'h0A, 1'b1}, rxq[1])
    `CHK("rx end", {8'h42, 1'b1}, rxq[2])
    cmd({1'b0, gpib_pkg::cmd_unl});
    `CHK("unlisten", 1'b0, listener)
    $display("listen test ends");
  end
  endtask : t_listen

  task t_talk;
  begin
    cmd(mta);
    `CHK("talker", 1'b1, talker)
    host_u.atn = 1'b0;
    tx = {8'h5A, 1'b1};
    tick(1);
    for (i = 0; i < 50 && tx_ready !== 1'b1; i++) tick(1);
    tx_valid = 1'b1;
    tick(1);
    tx_valid = 1'b0;
    `CHK("talk busy", 1'b0, tx_ready)
    host_u.get(gb, ge);
    `CHK("talk byte", {8'h5A, 1'b1}, {gb, ge})
    cmd(mla);
    `CHK("mla ends talk", 1'b0, talker)
    cmd(mta);
    `CHK("mta ends listen", 1'b0, listener)
    cmd(8'h46);
    `CHK("other talker", 1'b0, talker)
    cmd(mta);
    cmd({1'b0, gpib_pkg::cmd_unt});
    `CHK("untalk", 1'b0, talker)
    $display("talk test ends");
  end
  endtask : t_talk

  task t_poll;
  begin
    status_byte = 8'h11;
    service_req = 1'b1;
    tick(2);
    `CHK("srq", 1'b1, bus_out.srq_oe)
    cmd(mta);
    cmd({1'b0, gpib_pkg::cmd_spe});
    `CHK("poll on", 1'b1, serial_poll)
    host_u.get(gb, ge);
    `CHK("status", 8'h51, gb)
    cmd({1'b0, gpib_pkg::cmd_spd});
    `CHK("poll off", 1'b0, serial_poll)
    `CHK("srq polled", 1'b0, bus_out.srq_oe)
    service_req = 1'b0;
    cmd({1'b0, gpib_pkg::cmd_unt});
    $display("poll test ends");
  end
  endtask : t_poll

  task t_trig;
  begin
    cmd(mla);
    c0 = clr_n;
    t0 = trig_n;
    cmd({1'b0, gpib_pkg::cmd_dcl});
    `CHK("dcl", c0 + 1, clr_n)
    cmd({1'b0, gpib_pkg::cmd_sdc});
    `CHK("sdc", c0 + 2, clr_n)
    trig_src = gpib_pkg::trig_bus;
    cmd({1'b0, gpib_pkg::cmd_get});
    `CHK("get", t0 + 1, trig_n)
    trg_cmd = 1'b1;
    tick(1);
    trg_cmd = 1'b0;
    tick(3);
    `CHK("trg cmd", t0 + 2, trig_n)
    trig_src = gpib_pkg::trig_ext;
    cmd({1'b0, gpib_pkg::cmd_get});
    `CHK("get off bus", t0 + 2, trig_n)
    ext_trig = 1'b1;
    tick(4);
    ext_trig = 1'b0;
    `CHK("ext", t0 + 3, trig_n)
    trig_src = gpib_pkg::trig_imm;
    trig_arm = 1'b1;
    tick(1);
    trig_arm = 1'b0;
    tick(3);
    `CHK("imm", t0 + 4, trig_n)
    cmd({1'b0, gpib_pkg::cmd_ppc});
    `CHK("ppc ignored", 1'b1, listener)
    cmd({1'b0, gpib_pkg::cmd_unl});
    $display("trigger test ends");
  end
  endtask : t_trig

  task t_remote;
  begin
    keys_in = 8'h04;
    tick(2);
    `CHK("keys remote", 8'h00, keys_out)
    cmd({1'b0, gpib_pkg::cmd_gtl});
    `CHK("gtl ignored", 1'b1, remote)
    keys_in = 8'h01;
    tick(1);
    keys_in = 8'h04;
    tick(3);
    `CHK("local key", 1'b0, remote)
    `CHK("keys local", 8'h04, keys_out)
    {remote_mode_select_command, remote_mode_arg} = 2'h3;
    tick(1);
    remote_mode_select_command = 1'b0;
    lockout_cmd = 1'b1;
    tick(1);
    lockout_cmd = 1'b0;
    keys_in = 8'h01;
    tick(3);
    `CHK("remote cmd", 1'b1, remote)
    `CHK("lockout", 1'b1, lockout)
    {remote_mode_select_command, remote_mode_arg} = 2'h2;
    tick(1);
    remote_mode_select_command = 1'b0;
    tick(2);
    `CHK("remote zero", 1'b0, remote)
    host_u.ren = 1'b0;
    tick(2);
    `CHK("lockout off", 1'b0, lockout)
    host_u.ren = 1'b1;
    cmd(mta);
    host_u.ifc = 1'b1;
    tick(2);
    `CHK("ifc", 1'b0, talker)
    host_u.ifc = 1'b0;
    cmd({1'b0, gpib_pkg::cmd_llo});
    `CHK("bus lockout", 1'b1, lockout)
    $display("remote test ends");
  end
  endtask : t_remote

  task stop_test;
  begin
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask : stop_test

  initial
  begin
    {mclk, rst_n, tx_valid, rx_ready, eos_enable, service_req, lockout_cmd} = '0;
    {remote_mode_select_command, remote_mode_arg, ext_trig, trg_cmd, trig_arm} = '0;
    {status_byte, keys_in, tx} = '0;
    {bad_count, n_tests, trig_n, clr_n} = '0;
    my_addr = 5'h05;
    eos_char = 8'h0A;
    trig_src = gpib_pkg::trig_ext;
    tick(5);
    rst_n = 1'b1;
    rx_ready = 1'b1;
    eos_enable = 1'b1;
    tick(1);
    t_listen();
    t_talk();
    t_poll();
    t_trig();
    t_remote();
    stop_test();
  end

  initial
  begin
    repeat (30000) @(posedge mclk);
    bad_count++;
    stop_test();
  end
endmodule : test_gpib_talker_listener_port
